// *** design/drive_state_command_control.sv ***
// Operation
// - enable and fault-clear input edges switch states
// - control word bit map fixed
// - only bits 0-3 and 7 steer states
// - shutdown pattern goes to ready
// - bit1 low disables voltage under bus control, except in fault
// - quick stop to disabled or quick stop
// - disable operation returns to switched on
// - enable operation enters operation enable
// - bit8 high requests halt under bus control
// - bits 4-6 belong to active mode
// - one operating mode at a time
// - mode change only after termination
// - standstill terminates the active mode
// - modes start only in operation enable
// - mode select -6..6 starts mode, except 1 and 6 which only arm it
// - jog request bits, legal 0..7
// - position and homing start on bit4
// - mode codes -1, 1, 3, 6
// - state word encodes the state bits
// - fault left only after cause cleared
`default_nettype none
module drive_state_command_control #(
   parameter int unsigned WORD_W = 16
) (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rstn,
   // fieldbus parameter access
   input  wire logic [15:0]               param_addr,
   input  wire logic [WORD_W-1:0]         param_wdata,
   input  wire logic                      param_we,
   input  wire logic                      param_re,
   output logic      [WORD_W-1:0]         param_rdata,
   output logic                           param_rvalid,
   // discrete inputs and monitoring
   input  wire logic                      bus_ctl,
   input  wire logic                      enable_in,
   input  wire logic                      fault_reset_in,
   input  wire logic                      fault_in,
   input  wire logic                      mode_standstill,
   // to the motion profiles
   output drive_ctl_pkg::op_state_t       op_state,
   output logic                           halt_req,
   output logic                           mode_start,
   output logic                           mode_running,
   output logic signed [15:0]             active_mode,
   output logic      [2:0]                mode_settings,
   output drive_ctl_pkg::jog_req_t        jog_req
);
   import drive_ctl_pkg::*;

   if (WORD_W != 16) begin : g_width_check
      $error("WORD_W must be 16");
   end

   // ------------------------------------------------------------
   // parameter registers
   // ------------------------------------------------------------
   ctrl_word_t         cw_r, cw_nxt;
   logic signed [15:0] msel_r, msel_nxt;
   jog_req_t           jog_r, jog_nxt;
   logic               wr_cw, wr_msel, wr_jog, msel_legal;

   always_comb begin
      wr_cw      = param_we && (param_addr == OFS_CONTROL_WORD);
      wr_msel    = param_we && (param_addr == OFS_MODE_SELECT);
      wr_jog     = param_we && (param_addr == OFS_MANUAL_MOVE);
      msel_legal = ($signed(param_wdata) >= MODE_MIN) && ($signed(param_wdata) <= MODE_MAX);
      cw_nxt     = cw_r;
      msel_nxt   = msel_r;
      jog_nxt    = jog_r;
      // reserved bits are stored as written; the master keeps them zero
      if (wr_cw) cw_nxt = ctrl_word_t'(param_wdata);
      if (wr_msel && msel_legal) msel_nxt = $signed(param_wdata);
      // values above 7 are refused and the old request stays
      if (wr_jog && (param_wdata <= MANUAL_MOVE_MAX)) jog_nxt = jog_req_t'(param_wdata[2:0]);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cw_r   <= ctrl_word_t'(RST_CONTROL_WORD);
         msel_r <= RST_MODE_SELECT;
         jog_r  <= jog_req_t'(RST_MANUAL_MOVE);
      end else begin
         cw_r   <= cw_nxt;
         msel_r <= msel_nxt;
         jog_r  <= jog_nxt;
      end
   end

   // ------------------------------------------------------------
   // edge history
   // ------------------------------------------------------------
   logic en_q, sig_fr_q, cw_fr_q, cw_b4_q;
   logic en_rise, en_fall, sig_fr_rise, cw_fr_rise, cw_b4_rise;

   always_comb begin
      en_rise     = enable_in && !en_q;
      en_fall     = !enable_in && en_q;
      sig_fr_rise = fault_reset_in && !sig_fr_q;
      cw_fr_rise  = cw_r.fault_reset && !cw_fr_q;
      cw_b4_rise  = cw_r.mode_bits[0] && !cw_b4_q;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         en_q     <= 1'b0;
         sig_fr_q <= 1'b0;
         cw_fr_q  <= 1'b0;
         cw_b4_q  <= 1'b0;
      end else begin
         en_q     <= enable_in;
         sig_fr_q <= fault_reset_in;
         cw_fr_q  <= cw_r.fault_reset;
         cw_b4_q  <= cw_r.mode_bits[0];
      end
   end

   // ------------------------------------------------------------
   // operating state
   // ------------------------------------------------------------
   op_state_t state_r, state_nxt, cmd_nxt;

   drive_cmd_decode u_decode (
      .state       (state_r),
      .cw          (cw_r),
      .bus_ctl     (bus_ctl),
      .cw_fr_rise  (cw_fr_rise),
      .en_rise     (en_rise),
      .en_fall     (en_fall),
      .sig_fr_rise (sig_fr_rise),
      .fault_in    (fault_in),
      .state_nxt   (cmd_nxt)
   );

   // a monitored fault beats any command in the same cycle
   always_comb begin
      case (state_r)
         ST_NOT_READY:   state_nxt = ST_SW_DISABLED;
         ST_FAULT_REACT: state_nxt = ST_FAULT;
         ST_FAULT:       state_nxt = cmd_nxt;
         default:        state_nxt = fault_in ? ST_FAULT_REACT : cmd_nxt;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) state_r <= ST_NOT_READY;
      else state_r <= state_nxt;
   end

   // ------------------------------------------------------------
   // operating mode control
   // ------------------------------------------------------------
   logic               run_r, run_nxt, armed_r, armed_nxt, start_r, start_nxt;
   logic signed [15:0] act_r, act_nxt;
   logic               accept, bit4_mode, keep_mode;

   always_comb begin
      accept    = wr_msel && msel_legal && (state_r == ST_OP_ENABLE) && !run_r;
      bit4_mode = ($signed(param_wdata) == MODE_PROFILE_POS)
               || ($signed(param_wdata) == MODE_HOMING);
      keep_mode = (state_r == ST_OP_ENABLE) || (state_r == ST_QUICK_STOP);
      run_nxt   = run_r;
      armed_nxt = armed_r;
      start_nxt = 1'b0;
      act_nxt   = act_r;
      if (run_r && mode_standstill) run_nxt = 1'b0;
      if (accept) begin
         act_nxt   = $signed(param_wdata);
         armed_nxt = bit4_mode;
         run_nxt   = !bit4_mode;
         start_nxt = !bit4_mode;
      end else if (armed_r && cw_b4_rise && (state_r == ST_OP_ENABLE)) begin
         armed_nxt = 1'b0;
         run_nxt   = 1'b1;
         start_nxt = 1'b1;
      end
      // leaving the enabled states cancels the mode outright
      if (!keep_mode) begin
         run_nxt   = 1'b0;
         armed_nxt = 1'b0;
         start_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         run_r   <= 1'b0;
         armed_r <= 1'b0;
         start_r <= 1'b0;
         act_r   <= RST_MODE_SELECT;
      end else begin
         run_r   <= run_nxt;
         armed_r <= armed_nxt;
         start_r <= start_nxt;
         act_r   <= act_nxt;
      end
   end

   // ------------------------------------------------------------
   // state word and read path
   // ------------------------------------------------------------
   logic [15:0] sword, rd_nxt;

   always_comb begin
      sword = 16'h0000;
      case (state_r)
         ST_SW_DISABLED: sword[SW_DISABLED] = 1'b1;
         ST_READY:       sword[SW_QSTOP] = 1'b1;
         ST_SWITCHED_ON: sword[SW_QSTOP] = 1'b1;
         ST_OP_ENABLE:   sword[SW_QSTOP] = 1'b1;
         default:        sword[SW_QSTOP] = 1'b0;
      endcase
      sword[SW_READY]    = state_r inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLE,
                                           ST_QUICK_STOP, ST_FAULT_REACT, ST_FAULT};
      sword[SW_ON]       = state_r inside {ST_SWITCHED_ON, ST_OP_ENABLE,
                                           ST_QUICK_STOP, ST_FAULT_REACT, ST_FAULT};
      sword[SW_OP_EN]    = state_r inside {ST_OP_ENABLE, ST_QUICK_STOP,
                                           ST_FAULT_REACT, ST_FAULT};
      sword[SW_FAULT]    = state_r inside {ST_FAULT_REACT, ST_FAULT};
      sword[SW_HALT]     = halt_req;
      sword[SW_REMOTE]   = bus_ctl;
      sword[SW_MODE_END] = !run_r;
      case (param_addr)
         OFS_CONTROL_WORD: rd_nxt = cw_r;
         OFS_STATE_WORD:   rd_nxt = sword;
         OFS_MODE_SELECT:  rd_nxt = msel_r;
         OFS_ACTIVE_MODE:  rd_nxt = act_r;
         OFS_MANUAL_MOVE:  rd_nxt = {13'h0000, jog_r};
         default:          rd_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         param_rdata  <= '0;
         param_rvalid <= 1'b0;
      end else begin
         param_rdata  <= param_re ? rd_nxt : param_rdata;
         param_rvalid <= param_re;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_comb begin
      op_state      = state_r;
      halt_req      = bus_ctl && cw_r.halt;
      mode_start    = start_r;
      mode_running  = run_r;
      active_mode   = act_r;
      mode_settings = run_r ? cw_r.mode_bits : 3'h0;
      jog_req       = (run_r && act_r == MODE_JOG) ? jog_r : jog_req_t'(3'h0);
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_en_rise;
      !bus_ctl && en_rise && state_r == ST_READY && !fault_in |=> state_r == ST_OP_ENABLE;
   endproperty
   a_en_rise: assert property (p_en_rise) else $error("enable edge missed");

   property p_shutdown;
      bus_ctl && state_r == ST_SW_DISABLED && cw_r[2:0] == 3'h6 && !fault_in
         |=> state_r == ST_READY;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown missed");

   property p_dis_volt;
      bus_ctl && !cw_r.enable_voltage && !fault_in
         && state_r inside {ST_READY, ST_SWITCHED_ON, ST_OP_ENABLE, ST_QUICK_STOP}
         |=> state_r == ST_SW_DISABLED;
   endproperty
   a_dis_volt: assert property (p_dis_volt) else $error("disable voltage missed");

   property p_qstop;
      bus_ctl && cw_r[2:1] == 2'h1 && state_r == ST_OP_ENABLE && !fault_in
         |=> state_r == ST_QUICK_STOP;
   endproperty
   a_qstop: assert property (p_qstop) else $error("quick stop missed");

   property p_enable_op;
      bus_ctl && cw_r[3:0] == 4'hF && state_r == ST_SWITCHED_ON && !fault_in
         |=> state_r == ST_OP_ENABLE;
   endproperty
   a_enable_op: assert property (p_enable_op) else $error("enable operation missed");

   property p_fault_reset;
      bus_ctl && state_r == ST_FAULT && cw_fr_rise && !fault_in
         |=> state_r == ST_SW_DISABLED;
   endproperty
   a_fault_reset: assert property (p_fault_reset) else $error("fault reset missed");

   property p_fault_hold;
      state_r == ST_FAULT && fault_in |=> state_r == ST_FAULT;
   endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault left early");

   property p_one_mode;
      run_r && !mode_standstill && keep_mode && wr_msel |=> run_r && $stable(act_r);
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("mode changed while running");

   property p_standstill;
      run_r && mode_standstill && !accept |=> !run_r;
   endproperty
   a_standstill: assert property (p_standstill) else $error("mode not terminated");

   property p_start_in_op;
      mode_start |-> $past(state_r) == ST_OP_ENABLE && run_r;
   endproperty
   a_start_in_op: assert property (p_start_in_op) else $error("mode started outside");

   property p_no_match;
      bus_ctl && state_r == ST_SW_DISABLED && cw_r[2:0] == 3'h7 && !fault_in
         |=> state_r == ST_SW_DISABLED;
   endproperty
   a_no_match: assert property (p_no_match) else $error("state changed on no command");

   c_reach_op: cover property (state_r == ST_SWITCHED_ON ##1 state_r == ST_OP_ENABLE);
   c_jog_start: cover property (mode_start && act_r == MODE_JOG);
   c_bit4_start: cover property (armed_r ##[1:20] mode_start);
   c_fault_exit: cover property (state_r == ST_FAULT ##1 state_r == ST_SW_DISABLED);

endmodule // drive_state_command_control
`default_nettype wire

// *** design/drive_ctl_pkg.sv ***
`default_nettype none
package drive_ctl_pkg;

   // ------------------------------------------------------------
   // parameter addresses on the fieldbus
   // ------------------------------------------------------------
   localparam logic [15:0] OFS_CONTROL_WORD = 16'h1B02;
   localparam logic [15:0] OFS_STATE_WORD   = 16'h1B04;
   localparam logic [15:0] OFS_MODE_SELECT  = 16'h1B06;
   localparam logic [15:0] OFS_ACTIVE_MODE  = 16'h1B08;
   localparam logic [15:0] OFS_MANUAL_MOVE  = 16'h1B12;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_CONTROL_WORD = 16'h0000;
   localparam logic [15:0] RST_MODE_SELECT  = 16'h0000;
   localparam logic [2:0]  RST_MANUAL_MOVE  = 3'h0;

   // ------------------------------------------------------------
   // mode codes and limits
   // ------------------------------------------------------------
   localparam logic signed [15:0] MODE_MIN        = -16'sd6;
   localparam logic signed [15:0] MODE_MAX        = 16'sd6;
   localparam logic signed [15:0] MODE_PROFILE_POS = 16'sd1;
   localparam logic signed [15:0] MODE_PROFILE_VEL = 16'sd3;
   localparam logic signed [15:0] MODE_HOMING     = 16'sd6;
   localparam logic signed [15:0] MODE_JOG        = -16'sd1;
   localparam logic [15:0]        MANUAL_MOVE_MAX = 16'h0007;

   // ------------------------------------------------------------
   // state word bit positions
   // ------------------------------------------------------------
   localparam int SW_READY    = 0;
   localparam int SW_ON       = 1;
   localparam int SW_OP_EN    = 2;
   localparam int SW_FAULT    = 3;
   localparam int SW_QSTOP    = 5;
   localparam int SW_DISABLED = 6;
   localparam int SW_HALT     = 8;
   localparam int SW_REMOTE   = 9;
   localparam int SW_MODE_END = 14;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   // gray codes along the usual power-up path
   typedef enum logic [2:0] {
      ST_NOT_READY   = 3'h0,
      ST_SW_DISABLED = 3'h1,
      ST_READY       = 3'h3,
      ST_SWITCHED_ON = 3'h2,
      ST_OP_ENABLE   = 3'h6,
      ST_QUICK_STOP  = 3'h7,
      ST_FAULT_REACT = 3'h5,
      ST_FAULT       = 3'h4
   } op_state_t;

   typedef struct packed {
      logic [6:0] reserved;
      logic       halt;
      logic       fault_reset;
      logic [2:0] mode_bits;
      logic       enable_op;
      logic       quick_stop_n;
      logic       enable_voltage;
      logic       switch_on;
   } ctrl_word_t;

   typedef struct packed {
      logic fast;
      logic neg;
      logic pos;
   } jog_req_t;

endpackage
`default_nettype wire

// *** design/drive_cmd_decode.sv ***
`default_nettype none
module drive_cmd_decode (
   // current state and sources
   input  wire drive_ctl_pkg::op_state_t  state,
   input  wire drive_ctl_pkg::ctrl_word_t cw,
   input  wire logic                      bus_ctl,
   input  wire logic                      cw_fr_rise,
   input  wire logic                      en_rise,
   input  wire logic                      en_fall,
   input  wire logic                      sig_fr_rise,
   input  wire logic                      fault_in,
   // result
   output drive_ctl_pkg::op_state_t       state_nxt
);
   import drive_ctl_pkg::*;

   // ------------------------------------------------------------
   // command decode, bits 0..3 and 7 only
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state;
      if (bus_ctl) begin
         case (state)
            ST_FAULT: begin
               if (cw_fr_rise && !fault_in) state_nxt = ST_SW_DISABLED;
            end
            ST_SW_DISABLED: begin
               if (cw.enable_voltage && cw.quick_stop_n && !cw.switch_on)
                  state_nxt = ST_READY;
            end
            ST_READY: begin
               if (!cw.enable_voltage) state_nxt = ST_SW_DISABLED;
               else if (!cw.quick_stop_n) state_nxt = ST_SW_DISABLED;
               else if (cw.switch_on) state_nxt = ST_SWITCHED_ON;
            end
            ST_SWITCHED_ON: begin
               if (!cw.enable_voltage) state_nxt = ST_SW_DISABLED;
               else if (!cw.quick_stop_n) state_nxt = ST_SW_DISABLED;
               else if (!cw.switch_on) state_nxt = ST_READY;
               else if (cw.enable_op) state_nxt = ST_OP_ENABLE;
            end
            ST_OP_ENABLE: begin
               if (!cw.enable_voltage) state_nxt = ST_SW_DISABLED;
               else if (!cw.quick_stop_n) state_nxt = ST_QUICK_STOP;
               else if (!cw.switch_on) state_nxt = ST_READY;
               else if (!cw.enable_op) state_nxt = ST_SWITCHED_ON;
            end
            ST_QUICK_STOP: begin
               if (!cw.enable_voltage) state_nxt = ST_SW_DISABLED;
               else if (cw.quick_stop_n && cw.switch_on && cw.enable_op)
                  state_nxt = ST_OP_ENABLE;
            end
            default: state_nxt = state;
         endcase
      end else begin
         case (state)
            ST_READY, ST_SWITCHED_ON: begin
               if (en_rise) state_nxt = ST_OP_ENABLE;
            end
            ST_OP_ENABLE: begin
               if (en_fall) state_nxt = ST_READY;
            end
            ST_FAULT: begin
               if (sig_fr_rise && !fault_in) state_nxt = ST_READY;
            end
            ST_QUICK_STOP: begin
               if (sig_fr_rise) state_nxt = ST_OP_ENABLE;
            end
            default: state_nxt = state;
         endcase
      end
   end

endmodule // drive_cmd_decode
`default_nettype wire

// *** verif/fb_master.sv ***
`default_nettype none
module fb_master (
   // clock
   input  wire logic        ref_clk,
   // parameter access
   output logic      [15:0] param_addr,
   output logic      [15:0] param_wdata,
   output logic             param_we,
   output logic             param_re,
   input  wire logic [15:0] param_rdata,
   input  wire logic        param_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   import drive_ctl_pkg::*;

   initial begin
      param_addr  = 16'h0000;
      param_wdata = 16'h0000;
      param_we    = 1'b0;
      param_re    = 1'b0;
   end

   // -----------------
   // transfers
   // -----------------
   // released lines show the inverse, so a stale value never looks valid
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      param_addr  <= a;
      param_wdata <= (a == OFS_CONTROL_WORD) ? (d & 16'h01FF) : d;
      param_we    <= 1'b1;
      @(negedge ref_clk);
      param_we    <= 1'b0;
      param_addr  <= ~a;
      param_wdata <= ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      int n;
      @(negedge ref_clk);
      param_addr <= a;
      param_re   <= 1'b1;
      @(negedge ref_clk);
      param_re   <= 1'b0;
      param_addr <= ~a;
      n = 0;
      while (param_rvalid !== 1'b1 && n < 4) begin
         @(negedge ref_clk);
         n++;
      end
      d = (param_rvalid === 1'b1) ? param_rdata : 16'hXXXX;
   endtask

   // jog request goes first, the mode write starts it
   task automatic jog(input logic [15:0] req);
      wr(OFS_MANUAL_MOVE, req);
      wr(OFS_MODE_SELECT, MODE_JOG);
   endtask
endmodule // fb_master
`default_nettype wire

// *** verif/tb_drive_state_command_control.sv ***
`default_nettype none
module tb_drive_state_command_control;
   timeunit 1ns;
   timeprecision 1ns;
   import drive_ctl_pkg::*;

   // -----------------
   // signals
   // -----------------
   logic              ref_clk, rstn, bus_ctl, enable_in, fault_reset_in, fault_in;
   logic              mode_standstill, param_we, param_re, param_rvalid;
   logic              halt_req, mode_start, mode_running;
   logic       [15:0] param_addr, param_wdata, param_rdata, rv;
   logic signed[15:0] active_mode;
   logic       [2:0]  mode_settings;
   op_state_t         op_state;
   jog_req_t          jog_req;
   int                error_cnt, n_tests, cyc;

   // {control word, state one edge later}
   localparam logic [18:0] ROWS [12] = '{
      {16'h0006, ST_READY}, {16'h0087, ST_SWITCHED_ON}, {16'h000F, ST_OP_ENABLE},
      {16'h0007, ST_SWITCHED_ON}, {16'h000F, ST_OP_ENABLE}, {16'h000B, ST_QUICK_STOP},
      {16'h000F, ST_OP_ENABLE}, {16'h0071, ST_SW_DISABLED}, {16'h0007, ST_SW_DISABLED},
      {16'h0006, ST_READY}, {16'h0007, ST_SWITCHED_ON}, {16'h0003, ST_SW_DISABLED}};

   drive_state_command_control drive_state_command_control_i (
      .ref_clk(ref_clk), .rstn(rstn), .param_addr(param_addr), .param_wdata(param_wdata),
      .param_we(param_we), .param_re(param_re), .param_rdata(param_rdata),
      .param_rvalid(param_rvalid), .bus_ctl(bus_ctl), .enable_in(enable_in),
      .fault_reset_in(fault_reset_in), .fault_in(fault_in),
      .mode_standstill(mode_standstill), .op_state(op_state), .halt_req(halt_req),
      .mode_start(mode_start), .mode_running(mode_running), .active_mode(active_mode),
      .mode_settings(mode_settings), .jog_req(jog_req));

   fb_master fb_master_i (
      .ref_clk(ref_clk), .param_addr(param_addr), .param_wdata(param_wdata),
      .param_we(param_we), .param_re(param_re), .param_rdata(param_rdata),
      .param_rvalid(param_rvalid));

   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;

   // -----------------
   // checking
   // -----------------
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_st(input string nm, input op_state_t e);
      n_tests++;
      if (op_state !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, op_state);
      end
   endtask

   // discrete edges may be registered first, so allow a few cycles
   task automatic settle(input string nm, input op_state_t e);
      int n;
      n = 0;
      while (op_state !== e && n < 6) begin
         @(negedge ref_clk);
         n++;
      end
      chk_st(nm, e);
   endtask

   function automatic logic [15:0] sw_of(input op_state_t s);
      case (s)
         ST_SW_DISABLED: return 16'h0040;
         ST_READY:       return 16'h0021;
         ST_SWITCHED_ON: return 16'h0023;
         ST_OP_ENABLE:   return 16'h0027;
         ST_QUICK_STOP:  return 16'h0007;
         ST_FAULT:       return 16'h000F;
         default:        return 16'h0000;
      endcase
   endfunction

   task automatic setcw(input logic [15:0] d);
      fb_master_i.wr(OFS_CONTROL_WORD, d);
      @(negedge ref_clk);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a hang ends the run as a mismatch
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         $display("[ERR] cycle count expected below 3000 seen %0d", cyc);
         complete_run();
      end
   end

   // -----------------
   // sequence
   // -----------------
   initial begin
      {rstn, bus_ctl, enable_in, fault_reset_in, fault_in, mode_standstill} = 6'h00;
      repeat (11) @(negedge ref_clk);
      chk_st("state in reset", ST_NOT_READY);
      @(negedge ref_clk);
      rstn = 1'b1;
      bus_ctl = 1'b1;
      settle("state after reset", ST_SW_DISABLED);
      fb_master_i.rd(OFS_CONTROL_WORD, rv);
      chk16("control word reset", RST_CONTROL_WORD, rv);
      fb_master_i.rd(OFS_MODE_SELECT, rv);
      chk16("mode select reset", RST_MODE_SELECT, rv);
      fb_master_i.rd(OFS_MANUAL_MOVE, rv);
      chk16("manual move reset", 16'h0000, rv);
      fb_master_i.rd(16'h1B00, rv);
      chk16("unmapped read", 16'h0000, rv);
      $display("test reset done");
      foreach (ROWS[i]) begin
         setcw(ROWS[i][18:3]);
         chk_st("row state", op_state_t'(ROWS[i][2:0]));
         fb_master_i.rd(OFS_STATE_WORD, rv);
         chk16("row state word", sw_of(op_state_t'(ROWS[i][2:0])), rv & 16'h006F);
      end
      $display("test command rows done");
      setcw(16'h0006);
      setcw(16'h0007);
      fb_master_i.wr(OFS_MODE_SELECT, MODE_PROFILE_VEL);
      chk16("mode outside op enable", 16'h0000, 16'(mode_running));
      setcw(16'h000F);
      fb_master_i.jog(16'h0005);
      chk16("jog start", 16'h0001, 16'(mode_start));
      chk16("jog code", MODE_JOG, active_mode);
      chk16("jog request", 16'h0005, 16'(jog_req));
      @(negedge ref_clk);
      chk16("start pulse", 16'h0000, 16'(mode_start));
      fb_master_i.rd(OFS_ACTIVE_MODE, rv);
      chk16("active mode read", MODE_JOG, rv);
      fb_master_i.wr(OFS_MODE_SELECT, MODE_PROFILE_VEL);
      chk16("change while running", MODE_JOG, active_mode);
      setcw(16'h015F);
      chk16("mode settings", 16'h0005, 16'(mode_settings));
      chk16("halt request", 16'h0001, 16'(halt_req));
      fb_master_i.rd(OFS_STATE_WORD, rv);
      chk16("halt and mode bits", 16'h0300, rv & 16'h4300);
      mode_standstill = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk16("standstill ends mode", 16'h0000, 16'(mode_running));
      mode_standstill = 1'b0;
      $display("test jog done");
      setcw(16'h000F);
      fb_master_i.wr(OFS_MODE_SELECT, MODE_PROFILE_POS);
      @(negedge ref_clk);
      chk16("position waits", 16'h0000, 16'(mode_running));
      setcw(16'h001F);
      @(negedge ref_clk);
      chk16("position runs", 16'h0001, 16'(mode_running));
      chk16("position code", MODE_PROFILE_POS, active_mode);
      fb_master_i.wr(OFS_MODE_SELECT, 16'h0007);
      fb_master_i.rd(OFS_MODE_SELECT, rv);
      chk16("mode select range", 16'h0001, rv);
      fb_master_i.wr(OFS_MANUAL_MOVE, 16'h0008);
      fb_master_i.rd(OFS_MANUAL_MOVE, rv);
      chk16("manual move range", 16'h0005, rv);
      mode_standstill = 1'b1;
      repeat (2) @(negedge ref_clk);
      mode_standstill = 1'b0;
      fb_master_i.wr(OFS_MODE_SELECT, MODE_PROFILE_VEL);
      chk16("velocity code", MODE_PROFILE_VEL, active_mode);
      $display("test modes done");
      fault_in = 1'b1;
      settle("fault entry", ST_FAULT);
      chk16("fault cancels mode", 16'h0000, 16'(mode_running));
      setcw(16'h0006);
      setcw(16'h0086);
      chk_st("reset with cause", ST_FAULT);
      fault_in = 1'b0;
      setcw(16'h0006);
      setcw(16'h0086);
      chk_st("fault reset", ST_SW_DISABLED);
      $display("test fault done");
      setcw(16'h0006);
      bus_ctl = 1'b0;
      enable_in = 1'b1;
      settle("enable rise", ST_OP_ENABLE);
      enable_in = 1'b0;
      settle("enable fall", ST_READY);
      fault_in = 1'b1;
      settle("discrete fault", ST_FAULT);
      fault_in = 1'b0;
      fault_reset_in = 1'b1;
      settle("fault clear input", ST_READY);
      $display("test discrete done");
      complete_run();
   end
endmodule // tb_drive_state_command_control
`default_nettype wire
